/* File: verilog/flc_config_store.sv */
// fuse, lock bit, signature and calibration store with protection decode
`timescale 1ns/1ps
`include "flc_regs.svh"
module flc_config_store
  import flc_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE_0 = 8'h5A, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE_1 = 8'h3C, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE_2 = 8'h11, // arbitrary identity value
  parameter logic [7:0] CAL_BYTE = 8'h80
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire flc_mode_t mode_i,
  input wire flc_cmd_t cmd_i,
  input wire logic cmd_valid_i,
  input wire logic [1:0] byte_sel_i,
  input wire logic [7:0] wdata_i,
  input wire logic [1:0] sig_addr_i,
  output logic [7:0] fuse_rdata_o,
  output logic [7:0] sig_rdata_o,
  output logic [7:0] osc_calibration_reg_o,
  input wire logic store_req_i,
  input wire logic load_req_i,
  input wire logic [`FLC_PC_MSB:0] target_addr_i,
  input wire logic [`FLC_PC_MSB:0] exec_pc_i,
  input wire logic [`FLC_PC_MSB:0] boot_start_i,
  input wire logic vectors_in_app_i,
  output logic store_allow_o,
  output logic load_allow_o,
  output logic irq_disable_o,
  output logic [9:0] page_index_o,
  output logic [6:0] word_in_page_index_o,
  input wire logic [`FLC_EEA_MSB:0] eeprom_addr_i,
  output logic [8:0] eeprom_page_o,
  output logic [2:0] eeprom_byte_o,
  output logic prog_allow_o,
  output logic verify_allow_o,
  input wire logic sys_clock_i,
  input wire logic sleeping_i,
  output logic port_e_bit_seven_pin_o,
  output logic sleep_clock_keep_o,
  output logic eeprom_preserve_o,
  output logic [7:0] fuse_low_active_o,
  output logic [7:0] fuse_high_active_o,
  output logic [7:0] fuse_ext_active_o
);

  // ----------------------------------------------------------------
  // stored non-volatile state
  // ----------------------------------------------------------------
  logic [7:0] ext_q;
  logic [7:0] ext_d;
  logic [7:0] high_q;
  logic [7:0] high_d;
  logic [7:0] low_q;
  logic [7:0] low_d;
  logic [7:0] lock_q;
  logic [7:0] lock_d;
  logic [7:0] cal_q;
  logic [7:0] cal_d;
  flc_mode_t mode_q;
  logic fuse_wr_ok;
  logic fuse_load;
  logic boot_target;
  logic boot_exec;
  logic [1:0] boot_pair;

  // chip erase cannot touch fuses; a programmed memory lock one blocks them
  assign fuse_wr_ok = cmd_valid_i && (cmd_i == FLC_CMD_WRITE_FUSE)
                      && lock_q[`FLC_LK_MEM1];

  always_comb
  begin
    ext_d = ext_q;
    high_d = high_q;
    low_d = low_q;
    lock_d = lock_q;
    if (fuse_wr_ok)
    begin
      case (byte_sel_i)
        `FLC_SEL_FUSE_LOW: low_d = wdata_i;
        `FLC_SEL_FUSE_EXT: ext_d = wdata_i | ~`FLC_EXT_USED_MASK;
        `FLC_SEL_FUSE_HIGH:
        begin
          high_d = wdata_i;
          if (mode_i == FLC_MODE_SERIAL)
          begin
            high_d[`FLC_HB_SERIAL] = high_q[`FLC_HB_SERIAL];
          end
        end
        default: high_d = high_q;
      endcase
    end
    if (cmd_valid_i && (cmd_i == FLC_CMD_WRITE_LOCK))
    begin
      // writes can only program bits; boot locks frozen in lock mode 3
      if (lock_q[`FLC_LK_MEM2] || lock_q[`FLC_LK_MEM1])
      begin
        lock_d = lock_q & (wdata_i | ~`FLC_LOCK_USED_MASK);
      end
      else
      begin
        lock_d = lock_q & (wdata_i | 8'hFC);
      end
    end
    if (cmd_valid_i && (cmd_i == FLC_CMD_CHIP_ERASE))
    begin
      lock_d = `FLC_LOCK_RESET;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ext_q <= `FLC_EXT_RESET;
      high_q <= `FLC_HIGH_RESET;
      low_q <= `FLC_LOW_RESET;
      lock_q <= `FLC_LOCK_RESET;
    end
    else
    begin
      ext_q <= ext_d;
      high_q <= high_d;
      low_q <= low_d;
      lock_q <= lock_d;
    end
  end

  // ----------------------------------------------------------------
  // fuse latching
  // ----------------------------------------------------------------
  // reload on entering programming mode and on leaving it, and the cycle
  // after reset covers power-up in normal mode
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      mode_q <= FLC_MODE_NORMAL;
    end
    else
    begin
      mode_q <= mode_i;
    end
  end

  logic first_q;
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      first_q <= 1'b1;
    end
    else
    begin
      first_q <= 1'b0;
    end
  end

  assign fuse_load = (first_q && (mode_i == FLC_MODE_NORMAL))
                     || (mode_i != mode_q);

  flc_latch_if low_if ();
  flc_latch_if high_if ();
  flc_latch_if ext_if ();
  assign low_if.load = fuse_load;
  assign low_if.stored = low_q;
  assign low_if.pass = 1'b0;
  assign high_if.load = fuse_load;
  assign high_if.stored = high_q;
  assign high_if.pass = 1'b0;
  assign ext_if.load = fuse_load;
  assign ext_if.stored = ext_q;
  assign ext_if.pass = 1'b0;

  flc_fuse_latch #(.RESET_VAL(`FLC_LOW_RESET), .LIVE_MASK(8'h00)) u_low (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .lif(low_if)
  );
  flc_fuse_latch #(.RESET_VAL(`FLC_HIGH_RESET), .LIVE_MASK(8'h08)) u_high (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .lif(high_if)
  );
  flc_fuse_latch #(.RESET_VAL(`FLC_EXT_RESET), .LIVE_MASK(8'h00)) u_ext (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .lif(ext_if)
  );

  assign fuse_low_active_o = low_if.active;
  assign fuse_high_active_o = high_if.active;
  assign fuse_ext_active_o = ext_if.active;
  assign eeprom_preserve_o = ~high_if.active[`FLC_HB_PRESERVE];

  // ----------------------------------------------------------------
  // read back: fuses, locks, signature, calibration
  // ----------------------------------------------------------------
  logic [7:0] fuse_rd_d;
  logic [7:0] sig_rd_d;
  logic [7:0] fuse_rd_q;
  logic [7:0] sig_rd_q;

  always_comb
  begin
    case (byte_sel_i)
      `FLC_SEL_FUSE_LOW: fuse_rd_d = low_q;
      `FLC_SEL_LOCK: fuse_rd_d = lock_q | ~`FLC_LOCK_USED_MASK;
      `FLC_SEL_FUSE_EXT: fuse_rd_d = ext_q | ~`FLC_EXT_USED_MASK;
      default: fuse_rd_d = high_q;
    endcase
    // signature space ignores every lock setting
    case (sig_addr_i)
      `FLC_SIG_ADDR_0: sig_rd_d = SIG_BYTE_0;
      `FLC_SIG_ADDR_1: sig_rd_d = SIG_BYTE_1;
      `FLC_SIG_ADDR_2: sig_rd_d = SIG_BYTE_2;
      default: sig_rd_d = 8'hFF;
    endcase
    cal_d = cal_q;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      fuse_rd_q <= 8'hFF;
      sig_rd_q <= 8'h00;
      cal_q <= CAL_BYTE;
    end
    else
    begin
      fuse_rd_q <= fuse_rd_d;
      sig_rd_q <= sig_rd_d;
      cal_q <= cal_d;
    end
  end

  assign fuse_rdata_o = fuse_rd_q;
  assign sig_rdata_o = sig_rd_q;
  assign osc_calibration_reg_o = cal_q;

  // ----------------------------------------------------------------
  // boot section protection
  // ----------------------------------------------------------------
  assign boot_pair = {lock_q[`FLC_LK_BOOT_HI], lock_q[`FLC_LK_BOOT_LO]};
  assign boot_target = (target_addr_i >= boot_start_i);
  assign boot_exec = (exec_pc_i >= boot_start_i);

  always_comb
  begin
    store_allow_o = store_req_i;
    load_allow_o = load_req_i;
    irq_disable_o = 1'b0;
    case (boot_pair)
      2'b11:
      begin
        store_allow_o = store_req_i;
      end
      2'b10:
      begin
        store_allow_o = store_req_i && !boot_target;
      end
      2'b00:
      begin
        store_allow_o = store_req_i && !boot_target;
        load_allow_o = load_req_i && !(boot_target && !boot_exec);
        irq_disable_o = vectors_in_app_i && boot_exec;
      end
      default:
      begin
        load_allow_o = load_req_i && !(boot_target && !boot_exec);
        irq_disable_o = vectors_in_app_i && boot_exec;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // external programming permissions and geometry
  // ----------------------------------------------------------------
  assign prog_allow_o = lock_q[`FLC_LK_MEM1] && lock_q[`FLC_LK_MEM2];
  assign verify_allow_o = lock_q[`FLC_LK_MEM2];

  assign page_index_o = target_addr_i[`FLC_PC_MSB:`FLC_PC_WORD_MSB+1];
  assign word_in_page_index_o = target_addr_i[`FLC_PC_WORD_MSB:0];
  assign eeprom_page_o = eeprom_addr_i[`FLC_EEA_MSB:`FLC_EEA_BYTE_MSB+1];
  assign eeprom_byte_o = eeprom_addr_i[`FLC_EEA_BYTE_MSB:0];

  // ----------------------------------------------------------------
  // clock related fuse effects
  // ----------------------------------------------------------------
  assign port_e_bit_seven_pin_o = !low_if.active[`FLC_LB_CLKOUT]
                                  && sys_clock_i;
  assign sleep_clock_keep_o = sleeping_i
                              && !high_if.active[`FLC_HB_DEBUG_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_fuse_locked;
    @(posedge clock_i) disable iff (rst_i)
    !lock_q[`FLC_LK_MEM1] |=> $stable(low_q) && $stable(high_q);
  endproperty
  a_fuse_locked: assert property (p_fuse_locked)
    else $error("fuse changed while locked");

  property p_erase_keeps_fuse;
    @(posedge clock_i) disable iff (rst_i)
    cmd_valid_i && cmd_i == FLC_CMD_CHIP_ERASE |=> $stable(high_q)
      && lock_q == `FLC_LOCK_RESET;
  endproperty
  a_erase_keeps_fuse: assert property (p_erase_keeps_fuse)
    else $error("chip erase wrong");

  property p_ext_unused;
    @(posedge clock_i) disable iff (rst_i)
    ext_q[7:3] == 5'h1F;
  endproperty
  a_ext_unused: assert property (p_ext_unused)
    else $error("unused fuse bit low");

  property p_serial_fuse;
    @(posedge clock_i) disable iff (rst_i)
    mode_i == FLC_MODE_SERIAL |=> $stable(high_q[`FLC_HB_SERIAL]);
  endproperty
  a_serial_fuse: assert property (p_serial_fuse)
    else $error("serial fuse changed in serial mode");

  property p_latch_hold;
    @(posedge clock_i) disable iff (rst_i)
    !fuse_load |=> $stable(low_if.active);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("fuse took effect inside programming mode");

  property p_lock_no_clear;
    @(posedge clock_i) disable iff (rst_i)
    !(cmd_valid_i && cmd_i == FLC_CMD_CHIP_ERASE)
      |=> (lock_q & ~$past(lock_q)) == 8'h00;
  endproperty
  a_lock_no_clear: assert property (p_lock_no_clear)
    else $error("lock bit erased without chip erase");

  property p_boot_store;
    @(posedge clock_i) disable iff (rst_i)
    !boot_pair[0] && boot_target |-> !store_allow_o;
  endproperty
  a_boot_store: assert property (p_boot_store)
    else $error("store to protected boot section");

  property p_boot_load;
    @(posedge clock_i) disable iff (rst_i)
    !boot_pair[1] && boot_target && !boot_exec |-> !load_allow_o;
  endproperty
  a_boot_load: assert property (p_boot_load)
    else $error("load from protected boot section");

  property p_cal_reset;
    @(posedge clock_i)
    rst_i |=> osc_calibration_reg_o == CAL_BYTE;
  endproperty
  a_cal_reset: assert property (p_cal_reset)
    else $error("calibration not copied at reset");
endmodule

/* File: include/flc_regs.svh */
// constants for the fuse, lock and signature configuration store
// ----------------------------------------------------------------
// Function
// - boot lock 11 allows all; 10 blocks program-store writes to boot section
// - boot lock 00 blocks writes and app-side loads; 01 blocks only loads
// - boot modes 3,4 with app vectors: interrupts off while in boot code
// - three fuse bytes; programmed fuse reads zero, unprogrammed reads one
// - extended byte: bits 7..3 unused at one, bits 2..0 brownout level
// - high byte bits 7..4: debug, scan port, serial prog, watchdog defaults
// - high byte bits 3..0: preserve, boot size pair, reset vector defaults
// - low byte: div8 programmed, clkout off, startup 10, source 0010
// - serial programming mode cannot change the serial programming fuse
// - programmed clock output fuse drives system clock on port E bit 7
// - programmed debug fuse keeps part of clock running in all sleeps
// - chip erase keeps fuses; memory lock one programmed refuses fuse writes
// - fuses latched on programming entry; changes act only after exit
// - eeprom preserve fuse acts at once even inside programming mode
// - all fuses latched at power-up in normal mode
// - three signature bytes at 0x000..0x002, readable even when locked
// - calibration byte at signature_byte_0 high copied on every reset
// - flash: 1024 pages of 128 words, pc 6:0 word, 16:7 page
// - eeprom: 512 pages of 8 bytes, addr 2:0 byte, 11:3 page
// - lock bits return to one only through chip erase
// - memory lock 10 stops programming, locks fuses; 00 also verify, boot
// ----------------------------------------------------------------
`ifndef FLC_REGS_SVH
`define FLC_REGS_SVH

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define FLC_SIG_ADDR_0 2'h0
`define FLC_SIG_ADDR_1 2'h1
`define FLC_SIG_ADDR_2 2'h2
`define FLC_SEL_FUSE_LOW 2'h0
`define FLC_SEL_LOCK 2'h1
`define FLC_SEL_FUSE_EXT 2'h2
`define FLC_SEL_FUSE_HIGH 2'h3

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define FLC_EXT_RESET 8'hFF
`define FLC_EXT_USED_MASK 8'h07
`define FLC_HIGH_RESET 8'h99
`define FLC_LOW_RESET 8'h62
`define FLC_LOCK_RESET 8'hFF
`define FLC_LOCK_USED_MASK 8'h3F
`define FLC_HB_SERIAL 5
`define FLC_HB_PRESERVE 3
`define FLC_HB_DEBUG_BIT 7
`define FLC_LB_CLKOUT 6
`define FLC_LK_MEM1 0
`define FLC_LK_MEM2 1
`define FLC_LK_BOOT_LO 4
`define FLC_LK_BOOT_HI 5

// ----------------------------------------------------------------
// memory geometry
// ----------------------------------------------------------------
`define FLC_PC_MSB 16
`define FLC_PC_WORD_MSB 6
`define FLC_EEA_MSB 11
`define FLC_EEA_BYTE_MSB 2

`endif

/* File: include/flc_pkg.sv */
// types for the fuse, lock and signature configuration store
package flc_pkg;
  typedef enum logic [1:0] {
    FLC_MODE_NORMAL,
    FLC_MODE_PARALLEL,
    FLC_MODE_SERIAL
  } flc_mode_t;
  typedef enum logic [1:0] {
    FLC_CMD_NONE,
    FLC_CMD_WRITE_FUSE,
    FLC_CMD_WRITE_LOCK,
    FLC_CMD_CHIP_ERASE
  } flc_cmd_t;
endpackage

/* File: include/flc_latch_if.sv */
// carrier between the store and one latched fuse byte
`timescale 1ns/1ps
interface flc_latch_if;
  logic load;
  logic pass;
  logic [7:0] stored;
  logic [7:0] active;
  modport store (output load, output pass, output stored, input active);
  modport latch (input load, input pass, input stored, output active);
endinterface

/* File: verilog/flc_fuse_latch.sv */
// one latched fuse byte: copies stored value on load, LIVE_MASK bits follow live
`timescale 1ns/1ps
`include "flc_regs.svh"
module flc_fuse_latch
  import flc_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'hFF,
  parameter logic [7:0] LIVE_MASK = 8'h00
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  flc_latch_if.latch lif
);
  logic [7:0] held_q;
  logic [7:0] held_d;

  always_comb
  begin
    held_d = held_q;
    if (lif.load)
    begin
      held_d = lif.stored;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      held_q <= RESET_VAL;
    end
    else
    begin
      held_q <= held_d;
    end
  end

  // masked bits bypass the latch so they act at once
  assign lif.active = (held_q & ~LIVE_MASK) | (lif.stored & LIVE_MASK);
endmodule

/* File: sim/flc_prog_model.sv */
// programmer side model driving the fuse and lock command port
`timescale 1ns/1ps
module flc_prog_model
  import flc_pkg::*;
(
  input wire logic clock_i,
  input wire logic [7:0] fuse_rdata_i,
  output flc_mode_t mode_o,
  output flc_cmd_t cmd_o,
  output logic cmd_valid_o,
  output logic [1:0] byte_sel_o,
  output logic [7:0] wdata_o
);
  initial
  begin
    mode_o = FLC_MODE_NORMAL;
    cmd_o = FLC_CMD_NONE;
    cmd_valid_o = 1'b0;
    byte_sel_o = 2'h0;
    wdata_o = 8'h00;
  end
  // ----------------------------------------------------------------
  // command cycles
  // ----------------------------------------------------------------
  // held over one rising edge; data flips on release so stale data shows
  task automatic issue(input flc_cmd_t c, input logic [1:0] s,
    input logic [7:0] d);
    @(negedge clock_i);
    cmd_o = c;
    byte_sel_o = s;
    wdata_o = d;
    cmd_valid_o = 1'b1;
    @(negedge clock_i);
    cmd_valid_o = 1'b0;
    cmd_o = FLC_CMD_NONE;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    @(negedge clock_i);
    byte_sel_o = s;
    @(negedge clock_i);
    d = fuse_rdata_i;
  endtask
  task automatic set_mode(input flc_mode_t m);
    @(negedge clock_i);
    mode_o = m;
    @(negedge clock_i);
  endtask
endmodule

/* File: sim/fuse_lock_config_store_tb.sv */
// self-checking bench for the fuse, lock and signature store
`timescale 1ns/1ps
module fuse_lock_config_store_tb
  import flc_pkg::*;
;
  // signature and calibration values are arbitrary
  localparam logic [7:0] SIG0 = 8'hA7;
  localparam logic [7:0] SIG1 = 8'h4B;
  localparam logic [7:0] SIG2 = 8'hC3;
  localparam logic [7:0] CAL = 8'h6D;
  logic clock_i, rst_i, cmd_valid, vec_app, sys_clk, sleeping;
  flc_mode_t mode;
  flc_cmd_t cmd;
  logic [1:0] byte_sel, sig_addr;
  logic [7:0] wdata, fuse_rdata, sig_rdata, cal, act_lo, act_hi, act_ex;
  logic store_req, load_req, st_ok, ld_ok, irq_off, prog_ok, ver_ok;
  logic port_pin, keep, preserve;
  logic [16:0] target, exec_pc, boot_start;
  logic [9:0] page;
  logic [6:0] word;
  logic [11:0] ee_addr;
  logic [8:0] ee_page;
  logic [2:0] ee_byte;
  logic [7:0] v;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  flc_config_store #(.SIG_BYTE_0(SIG0), .SIG_BYTE_1(SIG1),
    .SIG_BYTE_2(SIG2), .CAL_BYTE(CAL)) dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .mode_i(mode), .cmd_i(cmd),
    .cmd_valid_i(cmd_valid), .byte_sel_i(byte_sel), .wdata_i(wdata),
    .sig_addr_i(sig_addr), .fuse_rdata_o(fuse_rdata),
    .sig_rdata_o(sig_rdata), .osc_calibration_reg_o(cal),
    .store_req_i(store_req), .load_req_i(load_req),
    .target_addr_i(target), .exec_pc_i(exec_pc),
    .boot_start_i(boot_start), .vectors_in_app_i(vec_app),
    .store_allow_o(st_ok), .load_allow_o(ld_ok), .irq_disable_o(irq_off),
    .page_index_o(page), .word_in_page_index_o(word),
    .eeprom_addr_i(ee_addr), .eeprom_page_o(ee_page),
    .eeprom_byte_o(ee_byte), .prog_allow_o(prog_ok),
    .verify_allow_o(ver_ok), .sys_clock_i(sys_clk),
    .sleeping_i(sleeping), .port_e_bit_seven_pin_o(port_pin),
    .sleep_clock_keep_o(keep), .eeprom_preserve_o(preserve),
    .fuse_low_active_o(act_lo), .fuse_high_active_o(act_hi),
    .fuse_ext_active_o(act_ex));
  flc_prog_model prog_u (
    .clock_i(clock_i), .fuse_rdata_i(fuse_rdata), .mode_o(mode),
    .cmd_o(cmd), .cmd_valid_o(cmd_valid), .byte_sel_o(byte_sel),
    .wdata_o(wdata));
  // ----------------------------------------------------------------
  // clock, timeout and checking
  // ----------------------------------------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic close_out();
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // a hang counts against the run rather than stalling it
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input logic [16:0] s, input logic [16:0] e);
    n_tests++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rchk(input logic [1:0] s, input logic [7:0] e);
    prog_u.rd(s, v);
    chk(17'(v), 17'(e));
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk(2'h0, 8'h62);
    rchk(2'h3, 8'h99);
    rchk(2'h2, 8'hFF);
    rchk(2'h1, 8'hFF);
    chk(17'({act_lo, act_hi}), 17'(16'h6299));
    chk(17'(act_ex), 17'(8'hFF));
    chk(17'(cal), 17'(CAL));
    chk(17'({port_pin, keep, preserve}), 17'(3'b000));
    chk(17'({prog_ok, ver_ok}), 17'(2'b11));
  endtask
  task automatic t_latch();
    prog_u.issue(FLC_CMD_WRITE_FUSE, 2'h2, 8'h00);
    rchk(2'h2, 8'hF8);
    prog_u.set_mode(FLC_MODE_PARALLEL);
    prog_u.issue(FLC_CMD_WRITE_FUSE, 2'h0, 8'h22);
    prog_u.issue(FLC_CMD_WRITE_FUSE, 2'h3, 8'h11);
    @(negedge clock_i);
    chk(17'(preserve), 17'(1'b1));
    chk(17'({act_lo, act_hi}), 17'(16'h6291));
    rchk(2'h0, 8'h22);
    prog_u.set_mode(FLC_MODE_NORMAL);
    chk(17'({act_lo, act_hi}), 17'(16'h2211));
    chk(17'(act_ex), 17'(8'hF8));
    chk(17'({port_pin, keep}), 17'(2'b11));
    sys_clk = 1'b0;
    sleeping = 1'b0;
    #1;
    chk(17'({port_pin, keep}), 17'(2'b00));
  endtask
  task automatic t_serial();
    prog_u.set_mode(FLC_MODE_SERIAL);
    prog_u.issue(FLC_CMD_WRITE_FUSE, 2'h3, 8'h31);
    rchk(2'h3, 8'h11);
    prog_u.set_mode(FLC_MODE_PARALLEL);
    prog_u.issue(FLC_CMD_WRITE_FUSE, 2'h3, 8'h31);
    rchk(2'h3, 8'h31);
  endtask
  task automatic t_boot();
    logic [1:0] p;
    // fuses and boot locks go in before any memory lock
    for (int i = 3; i >= 0; i--)
    begin
      p = 2'(i);
      prog_u.issue(FLC_CMD_CHIP_ERASE, 2'h1, 8'hFF);
      prog_u.issue(FLC_CMD_WRITE_LOCK, 2'h1, {2'b11, p, 4'hF});
      rchk(2'h1, {2'b11, p, 4'hF});
      target = 17'h1F000;
      exec_pc = 17'h00100;
      vec_app = 1'b1;
      #1;
      chk(17'({st_ok, ld_ok, irq_off}), 17'({p[0], p[1], 1'b0}));
      exec_pc = 17'h1E800;
      #1;
      chk(17'({ld_ok, irq_off}), 17'({1'b1, ~p[1]}));
      vec_app = 1'b0;
      #1;
      chk(17'(irq_off), 17'(1'b0));
    end
    prog_u.issue(FLC_CMD_WRITE_LOCK, 2'h1, 8'hFF);
    rchk(2'h1, 8'hCF);
    rchk(2'h3, 8'h31);
  endtask
  task automatic t_mem();
    logic [7:0] se [4];
    se = '{SIG0, SIG1, SIG2, 8'hFF};
    prog_u.issue(FLC_CMD_CHIP_ERASE, 2'h1, 8'hFF);
    prog_u.issue(FLC_CMD_WRITE_LOCK, 2'h1, 8'hFE);
    chk(17'({prog_ok, ver_ok}), 17'(2'b01));
    prog_u.issue(FLC_CMD_WRITE_FUSE, 2'h3, 8'hFF);
    rchk(2'h3, 8'h31);
    prog_u.issue(FLC_CMD_WRITE_LOCK, 2'h1, 8'hFC);
    chk(17'({prog_ok, ver_ok}), 17'(2'b00));
    prog_u.issue(FLC_CMD_WRITE_LOCK, 2'h1, 8'hC0);
    rchk(2'h1, 8'hFC);
    for (int i = 0; i < 4; i++)
    begin
      sig_addr = 2'(i);
      @(negedge clock_i);
      chk(17'(sig_rdata), 17'(se[i]));
    end
    chk(17'(cal), 17'(CAL));
  endtask
  task automatic t_geo();
    logic [16:0] a;
    logic [11:0] e;
    a = 17'h1ABCD;
    e = 12'hA5B;
    target = a;
    ee_addr = e;
    #1;
    chk(17'(page), 17'(10'h357));
    chk(17'(word), 17'(7'h4D));
    chk(17'(ee_page), 17'(9'h14B));
    chk(17'(ee_byte), 17'(3'h3));
  endtask
  initial
  begin
    rst_i = 1'b1;
    sig_addr = 2'h0;
    store_req = 1'b1;
    load_req = 1'b1;
    target = 17'h00000;
    exec_pc = 17'h00000;
    boot_start = 17'h1E000;
    vec_app = 1'b0;
    ee_addr = 12'h000;
    sys_clk = 1'b1;
    sleeping = 1'b1;
    repeat (5) @(negedge clock_i);
    rst_i = 1'b0;
    t_reset();
    t_latch();
    t_serial();
    t_boot();
    t_mem();
    t_geo();
    close_out();
  end
endmodule
